/* File: rtl/core_srb_pkg.sv */
// Behaviour
// (RULE1) Indirect data port has no storage; accesses go to the pointed register.
// (RULE2) Reading the timer count returns the live running Timer0 value.
// (RULE3) Writing the timer count replaces the Timer0 value at once.
// (RULE4) Timer0 counts instruction ticks, external pin edges or low-oscillator edges.
// (RULE5) PC low byte shows PC[7:0], resets to zero, increments per instruction.
// (RULE6) PC[9:8] are never written directly; they come from the high buffer.
// (RULE7) Short jump loads PC[8:0] from instruction, PC[9] from buffer bit 1.
// (RULE8) Short call loads PC[7:0] from instruction, PC[9:8] from buffer; pushes PC+1.
// (RULE9) Long jump/call load all ten PC bits; long call pushes PC+1.
// (RULE10) Carry set on add carry or subtract without borrow, else cleared.
// (RULE11) Half carry set on nibble carry or no nibble borrow, else cleared.
// (RULE12) Zero flag set when a logical result is zero, else cleared.
// (RULE13) Power-down flag is one after reset and watchdog clear; sleep clears it.
// (RULE14) Timeout flag is one after reset, watchdog clear or sleep; timeout clears.
// (RULE15) Spare general bits are plain read/write storage.
// (RULE16) Pointer low six bits select one of 64 locations.
// (RULE17) Pointer bank-select bits do not affect addressing.
// (RULE18) Port read gives pin level for inputs; outputs per readback option.
// (RULE19) Port write stores into the output data latches.
// (RULE20) Power control: interrupt select routes pin B0; watchdog enable resets one.
// (RULE21) Six wake-up enables, one per pin, all reset to one.
// (RULE22) Unimplemented bits ignore writes and read as zero; power control bit 3 ignores writes but reads as one.
package core_srb_pkg;

  localparam logic [5:0] ADDR_INDIRECT   = 6'h00;
  localparam logic [5:0] ADDR_TIMER0     = 6'h01;
  localparam logic [5:0] ADDR_PC_LOW     = 6'h02;
  localparam logic [5:0] ADDR_FLAGS      = 6'h03;
  localparam logic [5:0] ADDR_FSEL       = 6'h04;
  localparam logic [5:0] ADDR_PORT       = 6'h06;
  localparam logic [5:0] ADDR_PWR        = 6'h08;
  localparam logic [5:0] ADDR_WAKEUP     = 6'h09;
  localparam logic [5:0] ADDR_PC_HIGH    = 6'h0A;

  localparam int FLAG_CARRY     = 0;
  localparam int FLAG_HALF      = 1;
  localparam int FLAG_ZERO      = 2;
  localparam int FLAG_PDOWN     = 3;
  localparam int FLAG_TIMEOUT   = 4;
  localparam int PWR_EXT_INT    = 6;
  localparam int PWR_WDOG_EN    = 7;

  localparam logic [7:0] FLAGS_RESET    = 8'h18;
  localparam logic [7:0] FSEL_RESET     = 8'h00;
  localparam logic [9:0] PC_RESET       = 10'h000;
  localparam logic [7:0] PWR_RESET      = 8'h88;
  localparam logic [7:0] PWR_WMASK      = 8'hF7;
  localparam logic [7:0] PWR_FIXED      = 8'h08;
  localparam logic [5:0] WAKEUP_RESET   = 6'h3F;
  localparam logic [2:0] PC_HIGH_RESET  = 3'h0;
  localparam logic [7:0] TIMER0_RESET   = 8'h00;
  localparam logic [7:0] PORT_RESET     = 8'h00;

  typedef enum logic [2:0] {
    PC_HOLD,
    PC_STEP,
    PC_SHORT_JUMP,
    PC_SHORT_CALL,
    PC_LONG_JUMP,
    PC_LONG_CALL
  } pc_op_t;

  typedef struct packed {
    logic arith_valid;
    logic carry;
    logic half_carry;
    logic logic_valid;
    logic zero;
  } alu_flags_t;

  typedef struct packed {
    logic src_ext;
    logic use_lrc;
    logic falling_edge;
  } timer0_cfg_t;

  typedef struct packed {
    logic sleep;
    logic clear_watchdog;
    logic watchdog_timeout;
  } power_events_t;

endpackage

/* File: rtl/core_special_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module core_special_register_bank (
  input  wire logic                        clk_i,          // Core clock
  input  wire logic                        resetn_i,       // Async reset, low
  input  wire logic [5:0]                  addr_i,         // Direct address
  input  wire logic                        rd_en_i,        // Read strobe
  input  wire logic                        wr_en_i,        // Write strobe
  input  wire logic [7:0]                  wr_data_i,      // Write data
  output logic      [7:0]                  rd_data_o,      // Read data, 1 cycle
  output logic      [5:0]                  eff_addr_o,     // Resolved address
  output logic                             ext_sel_o,      // Target outside bank
  input  wire logic [7:0]                  ext_rd_data_i,  // Outside read data
  input  wire core_srb_pkg::pc_op_t        pc_op_i,        // PC update request
  input  wire logic [9:0]                  instr_addr_i,   // Instruction target
  output logic      [9:0]                  pc_o,           // Program counter
  output logic                             push_valid_o,   // Stack push pulse
  output logic      [9:0]                  push_addr_o,    // Return address
  input  wire core_srb_pkg::alu_flags_t    alu_i,          // ALU flag results
  input  wire core_srb_pkg::power_events_t pwr_evt_i,      // Sleep/wdt events
  input  wire logic                        inst_tick_i,    // Instruction clock
  input  wire core_srb_pkg::timer0_cfg_t   t0_cfg_i,       // Timer0 source cfg
  input  wire logic                        ext_clk_pin_i,  // Timer0 ext pin
  input  wire logic                        lrc_clk_i,      // Low oscillator
  output logic      [7:0]                  timer0_o,       // Timer0 count
  input  wire logic [5:0]                  pin_i,          // Port pin levels
  input  wire logic [5:0]                  pin_is_input_i, // Pin direction
  input  wire logic                        readback_opt_i, // 1: read latch
  output logic      [5:0]                  port_latch_o,   // Output latches
  output logic                             ext_int_o,      // B0 ext interrupt
  output logic                             watchdog_en_o,  // Watchdog enable
  output logic      [5:0]                  wakeup_en_o     // Per-pin wake-up
);

  logic [7:0] timer0_reg;
  logic [7:0] timer0_next;
  logic [9:0] pc_reg;
  logic [9:0] pc_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] fsel_reg;
  logic [7:0] port_reg;
  logic [7:0] pwr_reg;
  logic [5:0] wakeup_reg;
  logic [2:0] pc_high_reg;
  logic [7:0] rd_data_reg;
  logic       push_valid_reg;
  logic [9:0] push_addr_reg;
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [1:0] clk_s1_reg;
  logic [1:0] clk_s2_reg;
  logic       src_prev_reg;
  logic [7:0] rd_mux;

  // Indirect access resolves through the pointer; bank bits are dropped
  wire        via_ptr   = (addr_i == core_srb_pkg::ADDR_INDIRECT);     // [RULE1]
  wire [5:0]  tgt       = via_ptr ? fsel_reg[5:0] : addr_i; // [RULE16] [RULE17]
  wire        self_loop = via_ptr && (tgt == core_srb_pkg::ADDR_INDIRECT);
  wire        in_bank   = (tgt <= core_srb_pkg::ADDR_PC_HIGH);
  wire        wr_ok     = wr_en_i && !self_loop;

  wire wr_timer  = wr_ok && (tgt == core_srb_pkg::ADDR_TIMER0);
  wire wr_pc_low = wr_ok && (tgt == core_srb_pkg::ADDR_PC_LOW);
  wire wr_flags  = wr_ok && (tgt == core_srb_pkg::ADDR_FLAGS);
  wire wr_fsel   = wr_ok && (tgt == core_srb_pkg::ADDR_FSEL);
  wire wr_port   = wr_ok && (tgt == core_srb_pkg::ADDR_PORT);
  wire wr_pwr    = wr_ok && (tgt == core_srb_pkg::ADDR_PWR);
  wire wr_wakeup = wr_ok && (tgt == core_srb_pkg::ADDR_WAKEUP);
  wire wr_pc_hi  = wr_ok && (tgt == core_srb_pkg::ADDR_PC_HIGH);

  assign eff_addr_o = tgt;
  assign ext_sel_o  = (rd_en_i || wr_en_i) && !in_bank;

  // Timer0 source: instruction tick, or synchronised pin/low-osc edge
  wire src_level = t0_cfg_i.use_lrc ? clk_s2_reg[1] : clk_s2_reg[0];
  wire src_rise  = src_level && !src_prev_reg;
  wire src_fall  = !src_level && src_prev_reg;
  wire ext_edge  = t0_cfg_i.falling_edge ? src_fall : src_rise;
  wire t0_inc    = t0_cfg_i.src_ext ? ext_edge : inst_tick_i;        // [RULE4]

  assign timer0_next = wr_timer ? wr_data_i                          // [RULE3]
                     : t0_inc   ? 8'(timer0_reg + 8'h01)
                     : timer0_reg;

  // Program counter; writes to the low byte take the buffered high bits
  wire [9:0] pc_plus1 = 10'(pc_reg + 10'h001);
  wire       do_push  = !wr_pc_low && ((pc_op_i == core_srb_pkg::PC_SHORT_CALL)
                        || (pc_op_i == core_srb_pkg::PC_LONG_CALL));

  always_comb begin
    pc_next = pc_reg;
    if (wr_pc_low) begin
      pc_next = {pc_high_reg[1:0], wr_data_i};                       // [RULE6]
    end else begin
      case (pc_op_i)
        core_srb_pkg::PC_STEP: begin
          pc_next = pc_plus1;                                        // [RULE5]
        end
        core_srb_pkg::PC_SHORT_JUMP: begin
          pc_next = {pc_high_reg[1], instr_addr_i[8:0]};             // [RULE7]
        end
        core_srb_pkg::PC_SHORT_CALL: begin
          pc_next = {pc_high_reg[1:0], instr_addr_i[7:0]};           // [RULE8]
        end
        core_srb_pkg::PC_LONG_JUMP,
        core_srb_pkg::PC_LONG_CALL: begin
          pc_next = instr_addr_i;                                    // [RULE9]
        end
        default: begin
          pc_next = pc_reg;
        end
      endcase
    end
  end

  // Status flags: hardware events win over a software write
  always_comb begin
    flags_next = wr_flags ? wr_data_i : flags_reg;                   // [RULE15]
    if (alu_i.arith_valid) begin
      flags_next[core_srb_pkg::FLAG_CARRY] = alu_i.carry;            // [RULE10]
      flags_next[core_srb_pkg::FLAG_HALF]  = alu_i.half_carry;       // [RULE11]
    end
    if (alu_i.logic_valid) begin
      flags_next[core_srb_pkg::FLAG_ZERO] = alu_i.zero;              // [RULE12]
    end
    if (pwr_evt_i.clear_watchdog) begin
      flags_next[core_srb_pkg::FLAG_PDOWN]   = 1'b1;                 // [RULE13]
      flags_next[core_srb_pkg::FLAG_TIMEOUT] = 1'b1;                 // [RULE14]
    end
    if (pwr_evt_i.sleep) begin
      flags_next[core_srb_pkg::FLAG_PDOWN]   = 1'b0;                 // [RULE13]
      flags_next[core_srb_pkg::FLAG_TIMEOUT] = 1'b1;                 // [RULE14]
    end
    if (pwr_evt_i.watchdog_timeout) begin
      flags_next[core_srb_pkg::FLAG_TIMEOUT] = 1'b0;                 // [RULE14]
    end
  end

  // Port readback: inputs show the pin, outputs the pin or the latch
  wire [5:0] pin_view = (pin_is_input_i | ~{6{readback_opt_i}})
                        & pin_s2_reg
                      | (~pin_is_input_i & {6{readback_opt_i}})
                        & port_reg[5:0];                             // [RULE18]

  always_comb begin
    case (tgt)
      core_srb_pkg::ADDR_INDIRECT: rd_mux = 8'h00;                   // [RULE1]
      core_srb_pkg::ADDR_TIMER0:   rd_mux = timer0_reg;              // [RULE2]
      core_srb_pkg::ADDR_PC_LOW:   rd_mux = pc_reg[7:0];             // [RULE5]
      core_srb_pkg::ADDR_FLAGS:    rd_mux = flags_reg;
      core_srb_pkg::ADDR_FSEL:     rd_mux = fsel_reg;
      core_srb_pkg::ADDR_PORT:     rd_mux = {port_reg[7:6], pin_view};
      core_srb_pkg::ADDR_PWR:      rd_mux = pwr_reg;
      core_srb_pkg::ADDR_WAKEUP:   rd_mux = {2'h0, wakeup_reg};      // [RULE22]
      core_srb_pkg::ADDR_PC_HIGH:  rd_mux = {5'h00, pc_high_reg};    // [RULE22]
      default:                     rd_mux = in_bank ? 8'h00 : ext_rd_data_i;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_reg   <= 6'h00;
      pin_s2_reg   <= 6'h00;
      clk_s1_reg   <= 2'h0;
      clk_s2_reg   <= 2'h0;
      src_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= pin_i;
      pin_s2_reg   <= pin_s1_reg;
      clk_s1_reg   <= {lrc_clk_i, ext_clk_pin_i};
      clk_s2_reg   <= clk_s1_reg;
      src_prev_reg <= src_level;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer0_reg <= core_srb_pkg::TIMER0_RESET;
      pc_reg     <= core_srb_pkg::PC_RESET;
      flags_reg  <= core_srb_pkg::FLAGS_RESET;
    end else begin
      timer0_reg <= timer0_next;
      pc_reg     <= pc_next;
      flags_reg  <= flags_next;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fsel_reg    <= core_srb_pkg::FSEL_RESET;
      port_reg    <= core_srb_pkg::PORT_RESET;
      pwr_reg     <= core_srb_pkg::PWR_RESET;                        // [RULE20]
      wakeup_reg  <= core_srb_pkg::WAKEUP_RESET;                     // [RULE21]
      pc_high_reg <= core_srb_pkg::PC_HIGH_RESET;
    end else begin
      if (wr_fsel) begin
        fsel_reg <= wr_data_i;
      end
      if (wr_port) begin
        port_reg <= wr_data_i;                                       // [RULE19]
      end
      if (wr_pwr) begin
        pwr_reg <= (wr_data_i & core_srb_pkg::PWR_WMASK)
                 | core_srb_pkg::PWR_FIXED;                          // [RULE22]
      end
      if (wr_wakeup) begin
        wakeup_reg <= wr_data_i[5:0];                                // [RULE21]
      end
      if (wr_pc_hi) begin
        pc_high_reg <= wr_data_i[2:0];                               // [RULE15]
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_reg    <= 8'h00;
      push_valid_reg <= 1'b0;
      push_addr_reg  <= 10'h000;
    end else begin
      if (rd_en_i) begin
        rd_data_reg <= rd_mux;
      end
      push_valid_reg <= do_push;                             // [RULE8] [RULE9]
      if (do_push) begin
        push_addr_reg <= pc_plus1;
      end
    end
  end

  assign rd_data_o     = rd_data_reg;
  assign pc_o          = pc_reg;
  assign push_valid_o  = push_valid_reg;
  assign push_addr_o   = push_addr_reg;
  assign timer0_o      = timer0_reg;
  assign port_latch_o  = port_reg[5:0];
  assign ext_int_o     = pwr_reg[core_srb_pkg::PWR_EXT_INT]
                         && pin_s2_reg[0];                           // [RULE20]
  assign watchdog_en_o = pwr_reg[core_srb_pkg::PWR_WDOG_EN];         // [RULE20]
  assign wakeup_en_o   = wakeup_reg;                                 // [RULE21]

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_indirect_route;
    (addr_i == core_srb_pkg::ADDR_INDIRECT) |-> eff_addr_o == fsel_reg[5:0];
  endproperty
  a_indirect_route: assert property (p_indirect_route) // [RULE1] [RULE17]
    else $error("indirect access not routed by pointer");

  property p_timer_read_live;
    (rd_en_i && !via_ptr && addr_i == core_srb_pkg::ADDR_TIMER0)
      |=> rd_data_o == $past(timer0_reg);
  endproperty
  a_timer_read_live: assert property (p_timer_read_live) // [RULE2]
    else $error("timer read not live count");

  property p_timer_write;
    (wr_en_i && !via_ptr && addr_i == core_srb_pkg::ADDR_TIMER0)
      |=> timer0_o == $past(wr_data_i);
  endproperty
  a_timer_write: assert property (p_timer_write) // [RULE3]
    else $error("timer write did not load count");

  property p_timer_tick;
    (!t0_cfg_i.src_ext && inst_tick_i && !wr_timer)
      |=> timer0_o == 8'($past(timer0_o) + 8'h01);
  endproperty
  a_timer_tick: assert property (p_timer_tick) // [RULE4]
    else $error("timer missed instruction tick");

  property p_pc_step;
    (pc_op_i == core_srb_pkg::PC_STEP && !wr_pc_low)
      |=> pc_o == 10'($past(pc_o) + 10'h001);
  endproperty
  a_pc_step: assert property (p_pc_step) // [RULE5]
    else $error("pc did not step");

  property p_short_jump;
    (pc_op_i == core_srb_pkg::PC_SHORT_JUMP && !wr_pc_low)
      |=> pc_o == {$past(pc_high_reg[1]), $past(instr_addr_i[8:0])};
  endproperty
  a_short_jump: assert property (p_short_jump) // [RULE7]
    else $error("short jump target wrong");

  sequence s_call_req;
    pc_op_i == core_srb_pkg::PC_SHORT_CALL && !wr_pc_low;
  endsequence
  sequence s_call_done;
    push_valid_o && push_addr_o == 10'($past(pc_o, 1) + 10'h001)
      ##1 (!push_valid_o || $past(do_push));
  endsequence
  property p_short_call;
    s_call_req |=> s_call_done;
  endproperty
  a_short_call: assert property (p_short_call) // [RULE8]
    else $error("short call push wrong");

  property p_long_jump;
    (pc_op_i == core_srb_pkg::PC_LONG_JUMP && !wr_pc_low)
      |=> pc_o == $past(instr_addr_i) && !push_valid_o;
  endproperty
  a_long_jump: assert property (p_long_jump) // [RULE9]
    else $error("long jump wrong");

  property p_carry;
    alu_i.arith_valid |=> flags_reg[core_srb_pkg::FLAG_CARRY] == $past(alu_i.carry)
      && flags_reg[core_srb_pkg::FLAG_HALF] == $past(alu_i.half_carry);
  endproperty
  a_carry: assert property (p_carry) // [RULE10]
    else $error("carry flags not taken");

  property p_sleep;
    (pwr_evt_i.sleep && !pwr_evt_i.watchdog_timeout)
      |=> !flags_reg[core_srb_pkg::FLAG_PDOWN]
      && flags_reg[core_srb_pkg::FLAG_TIMEOUT];
  endproperty
  a_sleep: assert property (p_sleep) // [RULE13]
    else $error("sleep flags wrong");

  property p_timeout;
    pwr_evt_i.watchdog_timeout |=> !flags_reg[core_srb_pkg::FLAG_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) // [RULE14]
    else $error("timeout flag not cleared");

  property p_port_write;
    (wr_en_i && !via_ptr && addr_i == core_srb_pkg::ADDR_PORT)
      |=> port_latch_o == $past(wr_data_i[5:0]);
  endproperty
  a_port_write: assert property (p_port_write) // [RULE19]
    else $error("port latch not written");

  property p_pc_low_write;
    wr_pc_low
      |=> pc_o == {$past(pc_high_reg[1:0]), $past(wr_data_i)};
  endproperty
  a_pc_low_write: assert property (p_pc_low_write) // [RULE6]
    else $error("pc low write did not take buffer bits");

  property p_short_call_target;
    s_call_req
      |=> pc_o == {$past(pc_high_reg[1:0]), $past(instr_addr_i[7:0])};
  endproperty
  a_short_call_target: assert property (p_short_call_target) // [RULE8]
    else $error("short call target wrong");

  property p_long_call;
    (pc_op_i == core_srb_pkg::PC_LONG_CALL && !wr_pc_low)
      |=> pc_o == $past(instr_addr_i) && push_valid_o
      && push_addr_o == 10'($past(pc_o) + 10'h001);
  endproperty
  a_long_call: assert property (p_long_call) // [RULE9]
    else $error("long call wrong");

  property p_zero;
    alu_i.logic_valid
      |=> flags_reg[core_srb_pkg::FLAG_ZERO] == $past(alu_i.zero);
  endproperty
  a_zero: assert property (p_zero) // [RULE12]
    else $error("zero flag not taken");

  property p_clear_watchdog;
    (pwr_evt_i.clear_watchdog && !pwr_evt_i.sleep
      && !pwr_evt_i.watchdog_timeout)
      |=> flags_reg[core_srb_pkg::FLAG_PDOWN]
      && flags_reg[core_srb_pkg::FLAG_TIMEOUT];
  endproperty
  a_clear_watchdog: assert property (p_clear_watchdog) // [RULE13] [RULE14]
    else $error("watchdog clear flags wrong");

  property p_wakeup_write;
    wr_wakeup |=> wakeup_en_o == $past(wr_data_i[5:0]);
  endproperty
  a_wakeup_write: assert property (p_wakeup_write) // [RULE21]
    else $error("wake-up enables not written");

endmodule
`default_nettype wire

/* File: testbench/core_exec_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_exec_model (
  input  wire logic                 clk_i,     // Core clock
  input  wire logic [7:0]           rd_data_i, // Bank read data
  output logic      [5:0]           addr_o,    // Direct address
  output logic                      rd_en_o,   // Read strobe
  output logic                      wr_en_o,   // Write strobe
  output logic      [7:0]           wr_data_o, // Write data
  output var core_srb_pkg::pc_op_t  pc_op_o,   // PC request
  output logic      [9:0]           instr_o    // Instruction target
);
  initial begin
    addr_o = 6'h00;
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
    pc_op_o = core_srb_pkg::PC_HOLD;
    instr_o = 10'h000;
  end

  // Strobe held through its taking edge, then released
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wr_data_o = d;
    wr_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    wr_data_o = ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_en_o = 1'b0;
    d = rd_data_i;
  endtask

  task automatic pc(input core_srb_pkg::pc_op_t op, input logic [9:0] ia);
    @(posedge clk_i);
    #1;
    pc_op_o = op;
    instr_o = ia;
    @(posedge clk_i);
    #1;
    pc_op_o = core_srb_pkg::PC_HOLD;
    instr_o = ~ia;
  endtask
endmodule
`default_nettype wire

/* File: testbench/core_special_register_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
module core_special_register_bank_test;
  logic clk, resetn, rd_en, wr_en, ext_sel, push_valid, tick, ext_pin;
  logic lrc, opt, ext_int, wdog_en, ext_seen;
  logic [5:0] addr, eff_addr, pin, pin_in, latch, wake;
  logic [7:0] wr_data, rd_data, ext_rd, timer;
  logic [9:0] instr, pc, push_addr;
  core_srb_pkg::pc_op_t          pc_op;
  core_srb_pkg::alu_flags_t      alu;
  core_srb_pkg::power_events_t   pwr;
  core_srb_pkg::timer0_cfg_t     t0cfg;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [2:0] cfgs [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
  logic [2:0] ev_p [7] = '{3'h2, 3'h4, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [4:0] ev_a [7] = '{5'h00, 5'h00, 5'h00, 5'h1C, 5'h03, 5'h10, 5'h02};
  logic [7:0] ev_e [7] = '{8'hF8, 8'hF0, 8'hE0, 8'hE3, 8'hE7, 8'hE4, 8'hE0};
  logic [5:0] ra [6] = '{6'h02, 6'h03, 6'h04, 6'h08, 6'h09, 6'h0A};
  logic [7:0] rv [6] = '{8'h00, 8'h18, 8'h00, 8'h88, 8'h3F, 8'h00};

  // Outside storage answers with a tag of the resolved address
  assign ext_rd = {2'b10, eff_addr};

  // Outside-select as seen at the edge that takes a read
  always @(posedge clk) begin
    if (rd_en)
      ext_seen <= ext_sel;
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  core_exec_model core_exec_model_i (
    .clk_i(clk), .rd_data_i(rd_data), .addr_o(addr), .rd_en_o(rd_en),
    .wr_en_o(wr_en), .wr_data_o(wr_data), .pc_op_o(pc_op), .instr_o(instr)
  );

  core_special_register_bank core_special_register_bank_i (
    .clk_i(clk), .resetn_i(resetn), .addr_i(addr), .rd_en_i(rd_en),
    .wr_en_i(wr_en), .wr_data_i(wr_data), .rd_data_o(rd_data),
    .eff_addr_o(eff_addr), .ext_sel_o(ext_sel), .ext_rd_data_i(ext_rd),
    .pc_op_i(pc_op), .instr_addr_i(instr), .pc_o(pc),
    .push_valid_o(push_valid), .push_addr_o(push_addr), .alu_i(alu),
    .pwr_evt_i(pwr), .inst_tick_i(tick), .t0_cfg_i(t0cfg),
    .ext_clk_pin_i(ext_pin), .lrc_clk_i(lrc), .timer0_o(timer),
    .pin_i(pin), .pin_is_input_i(pin_in), .readback_opt_i(opt),
    .port_latch_o(latch), .ext_int_o(ext_int), .watchdog_en_o(wdog_en),
    .wakeup_en_o(wake)
  );

  task final_report;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      final_report();
    end
  end

  task chk(input logic [9:0] s, input logic [9:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask

  task wr(input logic [5:0] a, input logic [7:0] d);
    core_exec_model_i.wr(a, d);
  endtask

  task rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    core_exec_model_i.rd(a, d);
    chk({2'b00, d}, {2'b00, e});
  endtask

  task done(input string s);
    $display("Finished: %s", s);
  endtask

  task src_pulse(input int k);
    if (k == 0)
      tick = 1'b1;
    else if (k == 1)
      ext_pin = 1'b1;
    else
      lrc = 1'b1;
    @(posedge clk);
    #1;
    tick = 1'b0;
    ext_pin = 1'b0;
    lrc = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  initial begin
    resetn = 1'b0;
    alu = '0;
    pwr = '0;
    tick = 1'b0;
    t0cfg = '0;
    ext_pin = 1'b0;
    lrc = 1'b0;
    pin = 6'h2A;
    pin_in = 6'h0F;
    opt = 1'b1;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    for (int k = 0; k < 6; k++)
      rc(ra[k], rv[k]);
    chk(wdog_en, 10'h001);
    chk(wake, 10'h03F);
    done("reset values");
    wr(6'h09, 8'hFF);
    rc(6'h09, 8'h3F);
    wr(6'h09, 8'h00);
    chk(wake, 10'h000);
    wr(6'h0A, 8'hFF);
    rc(6'h0A, 8'h07);
    wr(6'h08, 8'h37);
    rc(6'h08, 8'h3F);
    chk(wdog_en, 10'h000);
    wr(6'h05, 8'hAA);
    rc(6'h05, 8'h00);
    done("storage bits");
    wr(6'h04, 8'hC9);
    rc(6'h04, 8'hC9);
    wr(6'h00, 8'h15);
    chk(wake, 10'h015);
    rc(6'h00, 8'h15);
    wr(6'h04, 8'h20);
    rc(6'h00, 8'hA0);
    chk(ext_seen, 10'h001);
    wr(6'h04, 8'h00);
    rc(6'h00, 8'h00);
    chk(ext_seen, 10'h000);
    done("indirect port");
    for (int k = 0; k < 4; k++) begin
      t0cfg = cfgs[k];
      wr(6'h01, 8'hFF);
      src_pulse(k);
      src_pulse(k);
      rc(6'h01, 8'h01);
      chk(timer, 10'h001);
    end
    done("timer");
    for (int k = 0; k < 3; k++)
      core_exec_model_i.pc(core_srb_pkg::PC_STEP, 10'h000);
    chk(pc, 10'h003);
    rc(6'h02, 8'h03);
    wr(6'h0A, 8'h02);
    core_exec_model_i.pc(core_srb_pkg::PC_SHORT_JUMP, 10'h1AB);
    chk(pc, 10'h3AB);
    chk(push_valid, 10'h000);
    core_exec_model_i.pc(core_srb_pkg::PC_SHORT_CALL, 10'h2CD);
    chk(pc, 10'h2CD);
    chk(push_valid, 10'h001);
    chk(push_addr, 10'h3AC);
    core_exec_model_i.pc(core_srb_pkg::PC_LONG_JUMP, 10'h155);
    chk(pc, 10'h155);
    core_exec_model_i.pc(core_srb_pkg::PC_LONG_CALL, 10'h0F0);
    chk(pc, 10'h0F0);
    chk(push_addr, 10'h156);
    wr(6'h02, 8'h77);
    chk(pc, 10'h277);
    done("program counter");
    wr(6'h03, 8'hE0);
    rc(6'h03, 8'hE0);
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      #1;
      pwr = ev_p[k];
      alu = ev_a[k];
      @(posedge clk);
      #1;
      pwr = '0;
      alu = '0;
      rc(6'h03, ev_e[k]);
    end
    done("flags");
    wr(6'h06, 8'hD5);
    chk(latch, 10'h015);
    rc(6'h06, 8'hDA);
    opt = 1'b0;
    rc(6'h06, 8'hEA);
    wr(6'h08, 8'h40);
    pin = 6'h2B;
    repeat (4) @(posedge clk);
    #1;
    chk(ext_int, 10'h001);
    wr(6'h08, 8'h00);
    chk(ext_int, 10'h000);
    done("port and power control");
    final_report();
  end
endmodule
`default_nettype wire
